// [logic/ppem_pkg.sv]
// Purpose : shared constants and carriers for the peripheral port monitor
// Assumes : 16-bit i/o addresses and data, one 100 MHz clock
// Notes   : register map sits in the i/o space served by the port itself
package ppem_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [15:0] PPEM_CFG_OFS = 16'h0100;
  localparam logic [15:0] PPEM_ERR_OFS = 16'h0102;
  localparam int          PPEM_CFG_EN_BIT  = 15;
  localparam int          PPEM_ERR_RNG_BIT = 15;
  localparam int          PPEM_ERR_TO_BIT  = 12;
  localparam int          PPEM_ERR_WR_BIT  = 4;
  localparam int          PPEM_ERR_RD_BIT  = 3;
  localparam logic        PPEM_CFG_EN_RST  = 1'b1;
  localparam logic [15:0] PPEM_ERR_RST     = 16'h0000;
  localparam logic [15:0] PPEM_ZERO16      = 16'h0000;

  // ----------------------------------------------------------------
  // monitored i/o address ranges
  // ----------------------------------------------------------------
  localparam logic [15:0] PPEM_RNG0_LO = 16'h0000;
  localparam logic [15:0] PPEM_RNG0_HI = 16'h03FF;
  localparam logic [15:0] PPEM_RNG1_LO = 16'h1400;
  localparam logic [15:0] PPEM_RNG1_HI = 16'h17FF;
  localparam logic [15:0] PPEM_RNG2_LO = 16'h2000;
  localparam logic [15:0] PPEM_RNG2_HI = 16'h23FF;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          PPEM_TO_CYCLES = 512;
  localparam int          PPEM_TO_W      = 10;
  localparam logic [9:0]  PPEM_TO_LAST   = 10'h1FF;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PPEM_ST_READY = 2'b00,
    PPEM_ST_WAIT  = 2'b01,
    PPEM_ST_SLEEP = 2'b10,
    PPEM_ST_HANG  = 2'b11
  } ppem_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic [15:0] wdata;
  } ppem_req_t;

endpackage

// [logic/ppem_timer.sv]
// Purpose : access age counter that flags a peripheral time-out
// Assumes : i_run stays high for the whole wait of one access
// Notes   : count clears whenever i_run drops
`timescale 1ns/100ps
module ppem_timer (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_run,
  output logic      o_expire
);
  import ppem_pkg::*;

  logic [PPEM_TO_W-1:0] cnt_r;

  // ----------------------------------------------------------------
  // counter, holds at its last value so a late enable still fires
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= '0;
    end else if (!i_run) begin
      cnt_r <= '0;
    end else if (cnt_r != PPEM_TO_LAST) begin
      cnt_r <= cnt_r + 10'h001;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_expire <= 1'b0;
    end else begin
      o_expire <= i_run && (cnt_r == PPEM_TO_LAST);
    end
  end

endmodule

// [logic/ppem_port.sv]
// Purpose : peripheral-side port between masters and peripheral registers
// Assumes : masters and peripherals run on i_clk; one access at a time
// Notes   : own registers answer in one cycle, others wait for the slave
`timescale 1ns/100ps

module ppem_port (
  input  wire logic               i_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_req,
  input  wire ppem_pkg::ppem_req_t i_req_d,
  output logic                    o_ready,
  output logic                    o_ack,
  output logic                    o_bus_err,
  output logic [15:0]             o_rdata,
  output logic                    o_per_req,
  output ppem_pkg::ppem_req_t     o_per_d,
  input  wire logic               i_per_ack,
  input  wire logic               i_per_inv,
  input  wire logic [15:0]        i_per_rdata,
  input  wire logic               i_timeout_en,
  input  wire logic               i_sleep_req,
  input  wire logic               i_idle_exec,
  input  wire logic               i_core_idle,
  input  wire logic               i_mport_idle,
  output logic                    o_sleeping,
  output logic                    o_sleep_err
);
  import ppem_pkg::*;

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  function automatic logic in_range(input logic [15:0] a);
    in_range = (a >= PPEM_RNG0_LO && a <= PPEM_RNG0_HI) ||
               (a >= PPEM_RNG1_LO && a <= PPEM_RNG1_HI) ||
               (a >= PPEM_RNG2_LO && a <= PPEM_RNG2_HI);
  endfunction

  function automatic logic is_own(input logic [15:0] a);
    is_own = (a == PPEM_CFG_OFS) || (a == PPEM_ERR_OFS);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ppem_state_t state_r;
  ppem_state_t state_nxt;
  ppem_req_t   cur_r;
  logic        cfg_en_r;
  logic [15:0] err_r;
  logic        expire;
  logic        take;
  logic        go_sleep;
  logic        own_hit;
  logic        rng_fail;
  logic        to_fail;
  logic        ok_done;

  assign take     = (state_r == PPEM_ST_READY) && i_req && !go_sleep;
  assign go_sleep = (state_r == PPEM_ST_READY) && i_sleep_req &&
                    i_idle_exec;
  assign own_hit  = take && is_own(i_req_d.addr);
  assign rng_fail = (state_r == PPEM_ST_WAIT) && i_per_ack && i_per_inv &&
                    in_range(cur_r.addr);
  assign to_fail  = (state_r == PPEM_ST_WAIT) && !i_per_ack && expire &&
                    i_timeout_en;
  assign ok_done  = (state_r == PPEM_ST_WAIT) && i_per_ack && !rng_fail;

  ppem_timer u_timer (
    .i_clk    (i_clk),
    .i_rst_n  (i_rst_n),
    .i_run    (state_r == PPEM_ST_WAIT),
    .o_expire (expire)
  );

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      PPEM_ST_READY: begin
        if (go_sleep) begin
          state_nxt = PPEM_ST_SLEEP;
        end else if (take && !own_hit) begin
          state_nxt = PPEM_ST_WAIT;
        end
      end
      PPEM_ST_WAIT: begin
        if (rng_fail && !cfg_en_r) begin
          state_nxt = PPEM_ST_HANG;
        end else if (i_per_ack || to_fail) begin
          state_nxt = PPEM_ST_READY;
        end
      end
      PPEM_ST_SLEEP: begin
        if (!i_sleep_req) begin
          state_nxt = PPEM_ST_READY;
        end
      end
      PPEM_ST_HANG: begin
        // only a device reset frees a pipeline stalled here
        state_nxt = PPEM_ST_HANG;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= PPEM_ST_READY;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ready    <= 1'b1;
      o_sleeping <= 1'b0;
    end else begin
      o_ready    <= (state_nxt == PPEM_ST_READY);
      o_sleeping <= (state_nxt == PPEM_ST_SLEEP);
    end
  end

  // ----------------------------------------------------------------
  // request capture and peripheral side
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cur_r <= '0;
    end else if (take) begin
      cur_r <= i_req_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_per_req <= 1'b0;
      o_per_d   <= '0;
    end else begin
      o_per_req <= take && !own_hit;
      if (take) begin
        o_per_d <= i_req_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // own registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_en_r <= PPEM_CFG_EN_RST;
    end else if (own_hit && i_req_d.wr &&
                 i_req_d.addr == PPEM_CFG_OFS) begin
      cfg_en_r <= i_req_d.wdata[PPEM_CFG_EN_BIT];
    end
  end

  // flags only ever set; no clear path exists short of reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      err_r <= PPEM_ERR_RST;
    end else begin
      if (rng_fail) begin
        err_r[PPEM_ERR_RNG_BIT] <= 1'b1;
        if (cur_r.wr) begin
          err_r[PPEM_ERR_WR_BIT] <= 1'b1;
        end else begin
          err_r[PPEM_ERR_RD_BIT] <= 1'b1;
        end
      end
      if (to_fail) begin
        err_r[PPEM_ERR_TO_BIT] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // answers to the requester
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ack     <= 1'b0;
      o_bus_err <= 1'b0;
      o_rdata   <= PPEM_ZERO16;
    end else begin
      o_ack     <= own_hit || ok_done;
      o_bus_err <= (rng_fail && cfg_en_r) || to_fail;
      if (own_hit) begin
        o_rdata <= PPEM_ZERO16;
        if (i_req_d.addr == PPEM_CFG_OFS) begin
          o_rdata[PPEM_CFG_EN_BIT] <= cfg_en_r;
        end else begin
          o_rdata <= err_r;
        end
      end else if (state_r == PPEM_ST_WAIT && i_per_ack) begin
        // passed through even on error; the consumer drops it
        o_rdata <= i_per_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // sleep misuse detection
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sleep_err <= 1'b0;
    end else begin
      o_sleep_err <= go_sleep && !i_core_idle && !i_mport_idle;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  localparam logic [9:0] TO_AGE = 10'(PPEM_TO_CYCLES);
  logic [9:0] age_r;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      age_r <= '0;
    end else if (state_r != PPEM_ST_WAIT) begin
      age_r <= '0;
    end else if (age_r != 10'h3FF) begin
      age_r <= age_r + 10'h001;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_rng_fail_en;
    rng_fail && cfg_en_r;
  endsequence

  sequence s_err_answer;
    o_bus_err && !o_ack && err_r[PPEM_ERR_RNG_BIT];
  endsequence

  chk_range_bus_err: assert property (
    s_rng_fail_en |=> s_err_answer
  ) else $error("range error not answered with bus error");

  chk_range_hang: assert property (
    (rng_fail && !cfg_en_r) |=>
      (state_r == PPEM_ST_HANG && !o_bus_err && !o_ack)[*4]
  ) else $error("disabled range error did not stall silently");

  chk_range_flag: assert property (
    $rose(err_r[PPEM_ERR_RNG_BIT]) |-> $past(rng_fail)
  ) else $error("range flag rose without a range error");

  chk_write_flag: assert property (
    (rng_fail && cur_r.wr) |=> err_r[PPEM_ERR_WR_BIT]
  ) else $error("write bus flag not set");

  chk_read_flag: assert property (
    (rng_fail && !cur_r.wr) |=> err_r[PPEM_ERR_RD_BIT]
  ) else $error("read bus flag not set");

  chk_timeout_flag: assert property (
    to_fail |=> o_bus_err && err_r[PPEM_ERR_TO_BIT] &&
               state_r == PPEM_ST_READY
  ) else $error("time-out not flagged");

  chk_timeout_age: assert property (
    expire && state_r == PPEM_ST_WAIT |-> age_r >= TO_AGE
  ) else $error("time-out fired before 512 cycles");

  chk_timeout_late: assert property (
    (state_r == PPEM_ST_WAIT && age_r == TO_AGE && i_timeout_en &&
     !i_per_ack) |-> to_fail
  ) else $error("time-out not declared at 512 cycles");

  chk_sleep_entry: assert property (
    go_sleep |=> o_sleeping && state_r == PPEM_ST_SLEEP
  ) else $error("sleep not entered");

  chk_sleep_cause: assert property (
    $rose(state_r == PPEM_ST_SLEEP) |-> $past(i_sleep_req && i_idle_exec)
  ) else $error("sleep entered without request");

  chk_sleep_silent: assert property (
    state_r == PPEM_ST_SLEEP |=> !o_per_req && !o_bus_err && !o_ack
  ) else $error("activity while asleep");

  chk_sleep_misuse: assert property (
    go_sleep && !i_core_idle && !i_mport_idle |=> o_sleep_err
  ) else $error("sleep misuse not reported");

  chk_own_read: assert property (
    own_hit && !i_req_d.wr |=> o_ack && !o_bus_err
  ) else $error("own register read not answered");

  chk_cfg_rsvd: assert property (
    own_hit && i_req_d.addr == PPEM_CFG_OFS |=> o_rdata[14:0] == 15'h0000
  ) else $error("config reserved bits not zero");

  chk_err_rsvd: assert property (
    (err_r & 16'h6FE7) == PPEM_ZERO16
  ) else $error("error register reserved bit set");

  chk_flags_sticky: assert property (
    ##1 $past(err_r) == ($past(err_r) & err_r)
  ) else $error("error flag cleared without reset");

  chk_answer_exclusive: assert property (
    !(o_ack && o_bus_err)
  ) else $error("access answered with both ack and bus error");

  chk_sleep_refuse: assert property (
    (state_r == PPEM_ST_SLEEP && i_req) |=> $stable(cur_r) && !o_ack
  ) else $error("request taken while asleep");

  chk_timeout_off: assert property (
    (state_r == PPEM_ST_WAIT && expire && !i_timeout_en && !i_per_ack) |=>
      (state_r == PPEM_ST_WAIT && !o_bus_err)
  ) else $error("time-out answered while disabled");

  chk_rdata_pass: assert property (
    (state_r == PPEM_ST_WAIT && i_per_ack) |=> o_rdata == $past(i_per_rdata)
  ) else $error("peripheral read data not passed on");

endmodule

// [verif/ppem_per_model.sv]
// Purpose : peripheral register model behind the port
// Assumes : one access at a time, answer delay chosen by the bench
// Notes   : read data toggles every cycle while no answer stands
`timescale 1ns/100ps
module ppem_per_model (
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  input  wire logic                i_per_req,
  input  wire ppem_pkg::ppem_req_t i_per_d,
  input  wire logic [3:0]          i_delay,
  input  wire logic                i_inv,
  input  wire logic                i_mute,
  output logic                     o_per_ack,
  output logic                     o_per_inv,
  output logic [15:0]              o_per_rdata
);
  import ppem_pkg::*;
  logic [4:0] wait_r;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_r      <= 5'h00;
      o_per_ack   <= 1'b0;
      o_per_inv   <= 1'b0;
      o_per_rdata <= 16'h0000;
    end else begin
      o_per_ack   <= 1'b0;
      o_per_inv   <= 1'b0;
      o_per_rdata <= ~o_per_rdata;
      // a muted module is disabled or idled and ignores new requests; one already counting still answers
      if (i_per_req && !i_mute) begin
        wait_r <= {1'b0, i_delay} + 5'h01;
      end else if (wait_r == 5'h01) begin
        wait_r      <= 5'h00;
        o_per_ack   <= 1'b1;
        o_per_inv   <= i_inv;
        o_per_rdata <= i_per_d.addr ^ 16'h5A3C;
      end else if (wait_r != 5'h00) begin
        wait_r <= wait_r - 5'h01;
      end
    end
  end
endmodule

// [verif/ppem_port_tb_top.sv]
// Purpose : self-checking bench for the peripheral port monitor
// Assumes : model answers after the bench-set delay, random only in the traffic test, unless muted
// Notes   : hang cases can only be left through a reset
`timescale 1ns/100ps
module ppem_port_tb_top;
  import ppem_pkg::*;
  logic        clk, rst_n, req, ready, ack, bus_err, per_req;
  logic        per_ack, per_inv, to_en, sleep_req, idle_exec, err;
  logic        core_idle, mport_idle, sleeping, sleep_err, inv, mute;
  logic [15:0] rdata, per_rdata, rd, a;
  logic [3:0]  dly;
  ppem_req_t   req_d, per_d;
  int          n, seed, miscompares, samples_checked;
  localparam logic [15:0] EDGES [10] = '{16'h0000, 16'h03FF, 16'h0400,
    16'h13FF, 16'h1400, 16'h17FF, 16'h1800, 16'h1FFF, 16'h2000, 16'h23FF};

  ppem_port DUT (.i_clk(clk), .i_rst_n(rst_n), .i_req(req),
    .i_req_d(req_d), .o_ready(ready), .o_ack(ack), .o_bus_err(bus_err),
    .o_rdata(rdata), .o_per_req(per_req), .o_per_d(per_d),
    .i_per_ack(per_ack), .i_per_inv(per_inv), .i_per_rdata(per_rdata),
    .i_timeout_en(to_en), .i_sleep_req(sleep_req),
    .i_idle_exec(idle_exec), .i_core_idle(core_idle),
    .i_mport_idle(mport_idle), .o_sleeping(sleeping),
    .o_sleep_err(sleep_err));
  ppem_per_model per_model (.i_clk(clk), .i_rst_n(rst_n),
    .i_per_req(per_req), .i_per_d(per_d), .i_delay(dly), .i_inv(inv),
    .i_mute(mute), .o_per_ack(per_ack), .o_per_inv(per_inv),
    .o_per_rdata(per_rdata));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic in_rng(input logic [15:0] x);
    return (x <= 16'h03FF) || (x >= 16'h1400 && x <= 16'h17FF) ||
           (x >= 16'h2000 && x <= 16'h23FF);
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic rst();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task automatic poke(input logic [15:0] ad, input logic w,
                      input logic [15:0] wd);
    @(posedge clk);
    req   <= 1'b1;
    req_d <= '{addr: ad, wr: w, wdata: wd};
    @(posedge clk);
    req <= 1'b0;
  endtask
  // waits are bounded so a lost answer cannot hang the run
  task automatic access(input logic [15:0] ad, input logic w,
                        input logic [15:0] wd);
    poke(ad, w, wd);
    n = 0;
    while (ack !== 1'b1 && bus_err !== 1'b1) begin
      @(posedge clk);
      n++;
      if (n > 2000) begin
        miscompares++;
        summarize();
      end
    end
    rd  = rdata;
    err = bus_err;
  endtask
  task automatic quiet(input int cyc);
    logic seen;
    seen = 1'b0;
    repeat (cyc) begin
      @(posedge clk);
      seen = seen | ack | bus_err;
    end
    chk({15'h0, seen}, 16'h0000);
    chk({15'h0, ready}, 16'h0000);
  endtask
  task automatic doze(input logic c, input logic m);
    @(posedge clk);
    core_idle  <= c;
    mport_idle <= m;
    idle_exec  <= 1'b1;
    @(posedge clk);
    idle_exec  <= 1'b0;
    sleep_req  <= 1'b1;
    repeat (4) @(posedge clk);
    chk({15'h0, sleeping}, 16'h0000);
    idle_exec <= 1'b1;
    @(posedge clk);
    idle_exec <= 1'b0;
    @(posedge clk);
    chk({15'h0, sleeping}, 16'h0001);
    chk({15'h0, sleep_err}, {15'h0, !(c || m)});
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'hD3D6;
    miscompares = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    req = 1'b0;
    req_d = '0;
    to_en = 1'b0;
    sleep_req = 1'b0;
    idle_exec = 1'b0;
    core_idle = 1'b0;
    mport_idle = 1'b0;
    inv = 1'b0;
    mute = 1'b0;
    dly = 4'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    access(16'h0100, 1'b0, 16'h0000);
    chk(rd, 16'h8000);
    access(16'h0102, 1'b0, 16'h0000);
    chk(rd, 16'h0000);
    access(16'h0100, 1'b1, 16'h7FFF);
    access(16'h0100, 1'b0, 16'h0000);
    chk(rd, 16'h0000);
    access(16'h0100, 1'b1, 16'hFFFF);
    access(16'h0102, 1'b1, 16'hFFFF);
    access(16'h0102, 1'b0, 16'h0000);
    chk(rd, 16'h0000);
    $display("test registers done");
    inv <= 1'b1;
    access(16'h0000, 1'b0, 16'h0000);
    chk({15'h0, err}, 16'h0001);
    access(16'h0102, 1'b0, 16'h0000);
    chk(rd, 16'h8008);
    access(16'h23FF, 1'b1, 16'h1234);
    access(16'h0102, 1'b0, 16'h0000);
    chk(rd, 16'h8018);
    foreach (EDGES[i]) begin
      access(EDGES[i], i[0], 16'h0000);
      chk({15'h0, err}, {15'h0, in_rng(EDGES[i])});
    end
    $display("test range errors done");
    for (int i = 0; i < 32; i++) begin
      a = 16'($random(seed));
      if (a[15:2] === 14'h0040) begin
        a = a ^ 16'h0800;
      end
      inv <= 1'($random(seed));
      dly <= 4'($random(seed));
      access(a, i[1], 16'($random(seed)));
      chk({15'h0, err}, {15'h0, inv && in_rng(a)});
      // data of an errored read is discarded
      if (!i[1] && !(inv && in_rng(a))) begin
        chk(rd, a ^ 16'h5A3C);
      end
    end
    $display("test random traffic done");
    mute <= 1'b1;
    to_en <= 1'b1;
    access(16'h3000, 1'b0, 16'h0000);
    chk({15'h0, err}, 16'h0001);
    chk({15'h0, n >= 512 && n <= 516}, 16'h0001);
    mute <= 1'b0;
    access(16'h0102, 1'b0, 16'h0000);
    chk(rd, 16'h9018);
    $display("test time-out done");
    for (int i = 0; i < 3; i++) begin
      doze(i == 1, i == 2);
      poke(16'h3000, 1'b0, 16'h0000);
      quiet(20);
      sleep_req <= 1'b0;
      repeat (3) @(posedge clk);
      chk({15'h0, ready}, 16'h0001);
    end
    $display("test sleep done");
    mute <= 1'b1;
    to_en <= 1'b0;
    poke(16'h3000, 1'b0, 16'h0000);
    quiet(600);
    rst();
    mute <= 1'b0;
    access(16'h0102, 1'b0, 16'h0000);
    chk(rd, 16'h0000);
    access(16'h0100, 1'b1, 16'h0000);
    inv <= 1'b1;
    poke(16'h1400, 1'b0, 16'h0000);
    quiet(60);
    rst();
    $display("test hang done");
    summarize();
  end
endmodule
